// *** logic/cpusbd_pkg.sv ***
// Behaviour
// - Halt instruction clears the interrupt mask
// - Interrupt wake keeps mask clear; reset sets
// - Halt gates clock; restart after settle delay
// - Break finishes instruction then runs software interrupt
// - Break vector FFFC, monitor mode FEFC
// - Return ends break once request deasserted
// - Add with carry, opcodes A9..F9, 9EE9, 9ED9
// - Add without carry, opcodes AB..FB, 9E forms
// - A7 adds signed immediate to stack pointer
// - AF adds signed immediate to index pair
// - 24 branches when carry clear, 3 cycles
// - Odd opcodes 11..1F clear memory bit n
// - Mask set blocks maskable interrupts
// - Reset sets mask; clear-mask and halt instructions clear it, return restores it
package cpusbd_pkg;
  // ==========================================
  // Opcodes
  localparam logic [7:0] OP_PREFIX = 8'h9e;
  localparam logic [7:0] OP_ADC_IMM = 8'ha9;
  localparam logic [7:0] OP_ADD_IMM = 8'hab;
  localparam logic [7:0] OP_ADD_SP_IMM = 8'ha7;
  localparam logic [7:0] OP_ADD_HX_IMM = 8'haf;
  localparam logic [7:0] OP_BRCC = 8'h24;
  localparam logic [7:0] OP_RET_INT = 8'h80;
  localparam logic [7:0] OP_SOFT_INT = 8'h83;
  localparam logic [7:0] OP_HALT = 8'h8e;
  localparam logic [7:0] OP_CLRI = 8'h9a;
  localparam logic [3:0] LO_ADC = 4'h9;
  localparam logic [3:0] LO_ADD = 4'hb;
  localparam logic [3:0] HI_BITCLR = 4'h1;
  localparam logic [3:0] HI_IMM = 4'ha;
  localparam logic [3:0] HI_DIR = 4'hb;
  localparam logic [3:0] HI_EXT = 4'hc;
  localparam logic [3:0] HI_IX2 = 4'hd;
  localparam logic [3:0] HI_IX1 = 4'he;
  localparam logic [3:0] HI_IX = 4'hf;
  // ==========================================
  // Vectors and reset values
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_IRQ = 16'hfffa;
  localparam logic [15:0] VEC_BRK = 16'hfffc;
  localparam logic [15:0] VEC_BRK_MON = 16'hfefc;
  localparam logic [15:0] SP_RESET = 16'h00ff;
  localparam logic [7:0] CCR_RESET = 8'h68;
  localparam int CCR_C = 0;
  localparam int CCR_Z = 1;
  localparam int CCR_N = 2;
  localparam int CCR_I = 3;
  localparam int CCR_H = 4;
  localparam int CCR_V = 7;
  localparam logic [15:0] BR_BIAS = 16'h0002;
  // ==========================================
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int OSC_SETTLE_NS = 40960;
  localparam int OSC_SETTLE_CYC = OSC_SETTLE_NS * CLK_MHZ / 1000;
  typedef struct packed {
    logic [15:0] adr;
    logic [7:0] dat;
    logic we;
  } cpusbd_req_t;
  typedef struct packed {
    logic [7:0] a;
    logic [15:0] hx;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0] condition_code_register;
  } cpusbd_regs_t;
endpackage : cpusbd_pkg

// *** logic/cpusbd_core.sv ***
`timescale 1ns/1ps
module cpusbd_core
  import cpusbd_pkg::*;
#(
  parameter int SETTLE_CYC = OSC_SETTLE_CYC
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic irq_pin,
  input wire logic break_req,
  input wire logic break_en,
  input wire logic monitor_mode,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [15:0] wb_adr_o,
  output logic [7:0] wb_dat_o,
  input wire logic [7:0] wb_dat_i,
  input wire logic wb_ack_i,
  output logic halted,
  output logic cpu_clk_gated,
  output logic in_break,
  output cpusbd_regs_t regs
);
  // ==========================================
  // Synchronise pins
  logic [2:0] irq_s_r, brk_s_r;
  logic irq_lvl_r, brk_lvl_r;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_s_r <= 3'h0;
      brk_s_r <= 3'h0;
      irq_lvl_r <= 1'b0;
      brk_lvl_r <= 1'b0;
    end else if (clk_en) begin
      irq_s_r <= {irq_s_r[1:0], irq_pin};
      brk_s_r <= {brk_s_r[1:0], break_req};
      if (irq_s_r[2] == irq_s_r[1]) irq_lvl_r <= irq_s_r[2];
      if (brk_s_r[2] == brk_s_r[1]) brk_lvl_r <= brk_s_r[2];
    end
  end
  // ==========================================
  // Sequencer
  typedef enum logic [3:0] {
    ST_VEC_HI, ST_VEC_LO, ST_FETCH, ST_FETCH2, ST_OPND, ST_ADRLO, ST_READ,
    ST_WRITE, ST_EXEC, ST_HALT, ST_SETTLE, ST_PUSH, ST_PULL
  } cpusbd_state_t;
  cpusbd_state_t st_r, st_nxt;
  logic [7:0] a_r, a_nxt, ccr_r, ccr_nxt, op_r, op_nxt, opnd_r, opnd_nxt;
  logic [15:0] hx_r, hx_nxt, sp_r, sp_nxt, pc_r, pc_nxt, ea_r, ea_nxt, vec_r, vec_nxt;
  logic pre_r, pre_nxt, brk_r, brk_nxt, irq_r, irq_nxt;
  logic fwait_r, fwait_nxt;
  logic [2:0] stk_r, stk_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic bus_busy;
  logic [8:0] sum;
  logic [4:0] hsum;
  logic [7:0] res;
  logic cin;
  logic take_irq, take_brk;
  cpusbd_req_t req;
  // No request while reset is held, so no stale ack meets the first vector read
  assign wb_cyc_o = bus_busy && !srst;
  assign wb_stb_o = bus_busy && !srst;
  assign wb_we_o = req.we;
  assign wb_adr_o = req.adr;
  assign wb_dat_o = req.dat;
  assign halted = (st_r == ST_HALT) || (st_r == ST_SETTLE);
  assign cpu_clk_gated = halted;
  assign in_break = brk_r;
  assign regs = '{a: a_r, hx: hx_r, sp: sp_r, pc: pc_r, condition_code_register: ccr_r};
  // Interrupts sampled only at instruction boundaries
  assign take_brk = break_en && brk_lvl_r && !brk_r;
  assign take_irq = irq_lvl_r && !ccr_r[CCR_I];
  always_comb begin
    st_nxt = st_r; a_nxt = a_r; ccr_nxt = ccr_r; op_nxt = op_r; opnd_nxt = opnd_r;
    hx_nxt = hx_r; sp_nxt = sp_r; pc_nxt = pc_r; ea_nxt = ea_r; vec_nxt = vec_r;
    pre_nxt = pre_r; brk_nxt = brk_r; irq_nxt = irq_r; stk_nxt = stk_r; cnt_nxt = cnt_r;
    bus_busy = 1'b0;
    fwait_nxt = 1'b0;
    req = '{adr: pc_r, dat: 8'h00, we: 1'b0};
    cin = (op_r[3:0] == LO_ADC) ? ccr_r[CCR_C] : 1'b0;
    sum = {1'b0, a_r} + {1'b0, opnd_r} + {8'h00, cin};
    hsum = {1'b0, a_r[3:0]} + {1'b0, opnd_r[3:0]} + {4'h0, cin};
    res = opnd_r & ~(8'h01 << op_r[3:1]);
    case (st_r)
      ST_VEC_HI: begin
        bus_busy = 1'b1;
        req.adr = vec_r;
        if (wb_ack_i) begin
          pc_nxt = {wb_dat_i, 8'h00};
          st_nxt = ST_VEC_LO;
        end
      end
      ST_VEC_LO: begin
        bus_busy = 1'b1;
        req.adr = vec_r + 16'h0001;
        if (wb_ack_i) begin
          pc_nxt = {pc_r[15:8], wb_dat_i};
          st_nxt = ST_FETCH;
        end
      end
      ST_FETCH: begin
        // A fetch already on the bus is finished first; dropping it breaks the handshake
        if (!fwait_r && (take_brk || take_irq)) begin
          // Break enters through the software-interrupt path
          brk_nxt = take_brk;
          irq_nxt = !take_brk;
          op_nxt = OP_SOFT_INT;
          stk_nxt = 3'h0;
          st_nxt = ST_PUSH;
        end else begin
          bus_busy = 1'b1;
          fwait_nxt = !wb_ack_i;
          if (wb_ack_i) begin
            pc_nxt = pc_r + 16'h0001;
            op_nxt = wb_dat_i;
            pre_nxt = (wb_dat_i == OP_PREFIX);
            irq_nxt = 1'b0;
            st_nxt = (wb_dat_i == OP_PREFIX) ? ST_FETCH2 : ST_OPND;
            if (wb_dat_i[7:4] == HI_IX && wb_dat_i[3:0] != 4'he) begin
              ea_nxt = hx_r;
              st_nxt = ST_READ;
            end
            if (wb_dat_i == OP_SOFT_INT) begin
              stk_nxt = 3'h0;
              st_nxt = ST_PUSH;
            end else if (wb_dat_i == OP_RET_INT) begin
              stk_nxt = 3'h0;
              st_nxt = ST_PULL;
            end else if (wb_dat_i == OP_HALT) begin
              ccr_nxt[CCR_I] = 1'b0;
              st_nxt = ST_HALT;
            end else if (wb_dat_i == OP_CLRI) begin
              ccr_nxt[CCR_I] = 1'b0;
              st_nxt = ST_FETCH;
            end
          end
        end
      end
      ST_FETCH2: begin
        bus_busy = 1'b1;
        if (wb_ack_i) begin
          pc_nxt = pc_r + 16'h0001;
          op_nxt = wb_dat_i;
          st_nxt = ST_OPND;
        end
      end
      ST_OPND: begin
        bus_busy = 1'b1;
        if (wb_ack_i) begin
          pc_nxt = pc_r + 16'h0001;
          opnd_nxt = wb_dat_i;
          ea_nxt = {8'h00, wb_dat_i};
          st_nxt = ST_EXEC;
          if (pre_r) begin
            ea_nxt = sp_r + {8'h00, wb_dat_i};
            st_nxt = (op_r[7:4] == HI_IX2) ? ST_ADRLO : ST_READ;
          end else if (op_r[7:4] == HI_EXT || op_r[7:4] == HI_IX2) begin
            st_nxt = ST_ADRLO;
          end else if (op_r[7:4] == HI_DIR || op_r[7:4] == HI_BITCLR) begin
            st_nxt = ST_READ;
          end else if (op_r[7:4] == HI_IX1) begin
            ea_nxt = hx_r + {8'h00, wb_dat_i};
            st_nxt = ST_READ;
          end
        end
      end
      ST_ADRLO: begin
        bus_busy = 1'b1;
        if (wb_ack_i) begin
          pc_nxt = pc_r + 16'h0001;
          ea_nxt = {opnd_r, wb_dat_i};
          if (pre_r) ea_nxt = sp_r + {opnd_r, wb_dat_i};
          else if (op_r[7:4] == HI_IX2) ea_nxt = hx_r + {opnd_r, wb_dat_i};
          st_nxt = ST_READ;
        end
      end
      ST_READ: begin
        bus_busy = 1'b1;
        req.adr = ea_r;
        if (wb_ack_i) begin
          opnd_nxt = wb_dat_i;
          st_nxt = (op_r[7:4] == HI_BITCLR) ? ST_WRITE : ST_EXEC;
        end
      end
      ST_WRITE: begin
        bus_busy = 1'b1;
        req = '{adr: ea_r, dat: res, we: 1'b1};
        if (wb_ack_i) st_nxt = ST_FETCH;
      end
      ST_EXEC: begin
        st_nxt = ST_FETCH;
        if (op_r == OP_ADD_SP_IMM) begin
          sp_nxt = sp_r + {{8{opnd_r[7]}}, opnd_r};
        end else if (op_r == OP_ADD_HX_IMM) begin
          hx_nxt = hx_r + {{8{opnd_r[7]}}, opnd_r};
        end else if (op_r == OP_BRCC) begin
          // Pc already points past the offset, i.e. start + 2
          if (!ccr_r[CCR_C]) pc_nxt = pc_r + {{8{opnd_r[7]}}, opnd_r};
        end else if (op_r[3:0] == LO_ADC || op_r[3:0] == LO_ADD) begin
          a_nxt = sum[7:0];
          ccr_nxt[CCR_C] = sum[8];
          ccr_nxt[CCR_H] = hsum[4];
          ccr_nxt[CCR_N] = sum[7];
          ccr_nxt[CCR_Z] = (sum[7:0] == 8'h00);
          ccr_nxt[CCR_V] = (a_r[7] == opnd_r[7]) && (sum[7] != a_r[7]);
        end
      end
      ST_HALT: begin
        if (irq_lvl_r) begin
          cnt_nxt = 16'h0000;
          st_nxt = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        cnt_nxt = cnt_r + 16'h0001;
        if (cnt_r >= 16'(SETTLE_CYC - 1)) st_nxt = ST_FETCH;
      end
      ST_PUSH: begin
        // Stack pc lo, pc hi, x, a, ccr
        bus_busy = 1'b1;
        req.we = 1'b1;
        req.adr = sp_r;
        case (stk_r)
          3'h0: req.dat = pc_r[7:0];
          3'h1: req.dat = pc_r[15:8];
          3'h2: req.dat = hx_r[7:0];
          3'h3: req.dat = a_r;
          default: req.dat = ccr_r;
        endcase
        if (wb_ack_i) begin
          sp_nxt = sp_r - 16'h0001;
          stk_nxt = stk_r + 3'h1;
          if (stk_r == 3'h4) begin
            ccr_nxt[CCR_I] = 1'b1;
            vec_nxt = brk_r ? (monitor_mode ? VEC_BRK_MON : VEC_BRK) :
                      (irq_r ? VEC_IRQ : VEC_BRK);
            st_nxt = ST_VEC_HI;
          end
        end
      end
      ST_PULL: begin
        bus_busy = 1'b1;
        req.adr = sp_r + 16'h0001;
        if (wb_ack_i) begin
          sp_nxt = sp_r + 16'h0001;
          stk_nxt = stk_r + 3'h1;
          case (stk_r)
            3'h0: ccr_nxt = wb_dat_i;
            3'h1: a_nxt = wb_dat_i;
            3'h2: hx_nxt = {hx_r[15:8], wb_dat_i};
            3'h3: pc_nxt = {wb_dat_i, 8'h00};
            default: pc_nxt = {pc_r[15:8], wb_dat_i};
          endcase
          if (stk_r == 3'h4) begin
            if (!brk_lvl_r) brk_nxt = 1'b0;
            st_nxt = ST_FETCH;
          end
        end
      end
      default: st_nxt = ST_FETCH;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_r <= ST_VEC_HI;
      a_r <= 8'h00;
      ccr_r <= CCR_RESET;
      op_r <= 8'h00;
      opnd_r <= 8'h00;
      hx_r <= 16'h0000;
      sp_r <= SP_RESET;
      pc_r <= 16'h0000;
      ea_r <= 16'h0000;
      vec_r <= VEC_RESET;
      pre_r <= 1'b0;
      brk_r <= 1'b0;
      irq_r <= 1'b0;
      stk_r <= 3'h0;
      cnt_r <= 16'h0000;
      fwait_r <= 1'b0;
    end else if (clk_en) begin
      st_r <= st_nxt;
      a_r <= a_nxt;
      ccr_r <= ccr_nxt;
      op_r <= op_nxt;
      opnd_r <= opnd_nxt;
      hx_r <= hx_nxt;
      sp_r <= sp_nxt;
      pc_r <= pc_nxt;
      ea_r <= ea_nxt;
      vec_r <= vec_nxt;
      pre_r <= pre_nxt;
      brk_r <= brk_nxt;
      irq_r <= irq_nxt;
      stk_r <= stk_nxt;
      cnt_r <= cnt_nxt;
      fwait_r <= fwait_nxt;
    end
  end
endmodule : cpusbd_core

// *** test/cpusbd_core_asserts.sv ***
`timescale 1ns/1ps
module cpusbd_core_asserts
  import cpusbd_pkg::*;
#(
  parameter int SETTLE_CYC = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic break_req,
  input wire logic break_en,
  input wire logic monitor_mode,
  input wire logic wb_cyc_o,
  input wire logic wb_we_o,
  input wire logic [15:0] wb_adr_o,
  input wire logic wb_ack_i,
  input wire logic halted,
  input wire logic cpu_clk_gated,
  input wire logic in_break,
  input wire cpusbd_regs_t regs
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // ==========================================
  // Length of the current gated stretch
  logic [15:0] gcnt_r;
  logic [15:0] gcnt_nxt;
  always_comb gcnt_nxt = cpu_clk_gated ? gcnt_r + 16'h0001 : 16'h0000;
  always_ff @(posedge ref_clk) gcnt_r <= srst ? 16'h0000 : gcnt_nxt;
  // ==========================================
  // Checks
  sequence brk_fetch; wb_cyc_o && !wb_we_o && wb_adr_o == VEC_BRK; endsequence
  sequence mon_fetch; wb_cyc_o && !wb_we_o && wb_adr_o == VEC_BRK_MON; endsequence
  halt_mask_a: assert property ($rose(halted) |-> ##[0:2] !regs.condition_code_register[CCR_I])
    else $error("mask still set after halt");
  reset_mask_a: assert property ($fell(srst) |-> regs.condition_code_register[CCR_I])
    else $error("mask clear after reset");
  settle_wait_a: assert property ($fell(cpu_clk_gated) |-> gcnt_r >= SETTLE_CYC)
    else $error("clock restarted before settle delay");
  halt_gate_a: assert property (halted |-> cpu_clk_gated && !wb_cyc_o)
    else $error("bus active while halted");
  brk_vec_a: assert property (brk_fetch |-> !monitor_mode && in_break)
    else $error("normal break vector in wrong mode");
  mon_vec_a: assert property (mon_fetch |-> monitor_mode && in_break)
    else $error("monitor break vector in wrong mode");
  brk_enable_a: assert property ($rose(in_break) |-> $past(break_en))
    else $error("break taken while unit disabled");
  brk_exit_a: assert property ($fell(in_break) |-> !$past(break_req))
    else $error("break left while request high");
  bus_hold_a: assert property (wb_cyc_o && !wb_ack_i |=> wb_cyc_o && $stable(wb_adr_o))
    else $error("request dropped before ack");
endmodule : cpusbd_core_asserts

bind cpusbd_core cpusbd_core_asserts #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.*);

// *** test/cpusbd_mem_model.sv ***
`timescale 1ns/1ps
module cpusbd_mem_model (
  input wire logic ref_clk,
  input wire logic slow,
  input wire logic cyc,
  input wire logic stb,
  input wire logic we,
  input wire logic [15:0] adr,
  input wire logic [7:0] dat_w,
  output logic [7:0] dat_r,
  output logic ack
);
  logic [7:0] mem [0:65535];
  logic ack_r, ack_nxt, wait_r, wait_nxt;
  // Slow mode inserts one wait state before each ack
  always_comb begin
    wait_nxt = cyc && stb && !ack_r && !wait_r;
    ack_nxt = cyc && stb && !ack_r && (!slow || wait_r);
  end
  always_ff @(posedge ref_clk) begin
    ack_r <= ack_nxt;
    wait_r <= wait_nxt;
  end
  always @(posedge ref_clk) begin
    if (cyc && stb && we && ack_r) begin
      mem[adr] <= dat_w;
    end
  end
  // Outside an acked cycle the data lines show inverted data, never a stale copy
  assign dat_r = ack_r ? mem[adr] : ~mem[adr];
  assign ack = ack_r;
endmodule : cpusbd_mem_model

// *** test/test_cpusbd_core.sv ***
`timescale 1ns/1ps
module test_cpusbd_core;
  import cpusbd_pkg::*;
  localparam int SC = 8;
  typedef struct packed {logic [39:0] prog; logic [2:0] sel; logic [15:0] exp;} cpusbd_row_t;
  logic ref_clk, srst, clk_en, irq_pin, break_req, break_en, monitor_mode, slow;
  logic wb_cyc_o, wb_stb_o, wb_we_o, wb_ack_i, halted, cpu_clk_gated, in_break;
  logic [15:0] wb_adr_o, last_rd, hx0;
  logic [7:0] wb_dat_o, wb_dat_i, a0;
  logic [8:0] t, u;
  cpusbd_regs_t regs;
  int fails, check_count, k, r, n;
  cpusbd_row_t rows [6] = '{
    '{40'ha7fe8e8e8e, 3'd0, 16'h00fd}, '{40'ha7028e8e8e, 3'd0, 16'h0101},
    '{40'haf818e8e8e, 3'd1, 16'hff81}, '{40'h24028e8e8e, 3'd2, 16'h0104},
    '{40'hab10a9018e, 3'd3, 16'h1001}, '{40'habf0a9208e, 3'd3, 16'hf020}};
  cpusbd_core #(.SETTLE_CYC(SC)) u_cpusbd_core (.*);
  cpusbd_mem_model u_cpusbd_mem_model (.ref_clk(ref_clk), .slow(slow), .cyc(wb_cyc_o),
    .stb(wb_stb_o), .we(wb_we_o), .adr(wb_adr_o), .dat_w(wb_dat_o), .dat_r(wb_dat_i),
    .ack(wb_ack_i));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (wb_cyc_o && wb_ack_i && !wb_we_o) begin
      last_rd <= wb_adr_o;
    end
  end
  // ==========================================
  // Tasks
  task automatic conclude();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bounded(input int lim, input string nm);
    if (k >= lim) begin
      fails++;
      $display("MISMATCH %s expected done seen timeout", nm);
      conclude();
    end
  endtask : bounded
  // Loads five program bytes at 0100 and restarts the core on them
  task automatic run(input logic [39:0] p);
    @(posedge ref_clk);
    for (k = 0; k < 5; k++) u_cpusbd_mem_model.mem[16'h0100 + k] = p[39 - 8 * k -: 8];
    srst <= 1'b1;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    a0 = regs.a;
    hx0 = regs.hx;
  endtask : run
  task automatic wait_halt();
    for (k = 0; k < 400 && halted !== 1'b1; k++) @(negedge ref_clk);
    bounded(400, "halt");
    chk("mask", 16'h0000, {15'h0, regs.condition_code_register[CCR_I]});
  endtask : wait_halt
  // ==========================================
  // Sequence
  initial begin
    {srst, irq_pin, break_req, break_en, monitor_mode, slow} = 6'h20;
    clk_en = 1'b1;
    fails = 0;
    check_count = 0;
    last_rd = 16'h0000;
    u_cpusbd_mem_model.mem[16'hfffe] = 8'h01;
    u_cpusbd_mem_model.mem[16'hffff] = 8'h00;
    u_cpusbd_mem_model.mem[16'hfffa] = 8'h01;
    u_cpusbd_mem_model.mem[16'hfffb] = 8'h00;
    for (r = 0; r < 6; r++) begin
      slow <= r[0];
      run(rows[r].prog);
      wait_halt();
      t = {1'b0, a0} + rows[r].exp[15:8];
      u = t[7:0] + {7'h0, t[8]} + rows[r].exp[7:0];
      case (rows[r].sel)
        3'd0: chk("sp", rows[r].exp, regs.sp);
        3'd1: chk("hx", rows[r].exp, regs.hx - hx0);
        3'd2: chk("branch", rows[r].exp, last_rd);
        default: chk("acc", {7'h0, u}, {7'h0, regs.condition_code_register[CCR_C], regs.a});
      endcase
      if (rows[r].sel != 3'd3) chk("ccr", {8'h0, CCR_RESET & 8'hf7}, {8'h0, regs.condition_code_register});
    end
    for (n = 0; n < 8; n++) begin
      u_cpusbd_mem_model.mem[16'h0040] = 8'hff;
      run({8'h11 + 8'(2 * n), 32'h408e8e8e});
      wait_halt();
      chk("bitclr", {8'h0, ~(8'h01 << n)}, {8'h0, u_cpusbd_mem_model.mem[16'h0040]});
    end
    @(posedge ref_clk);
    irq_pin <= 1'b1;
    for (k = 0; k < 200 && cpu_clk_gated !== 1'b0; k++) @(negedge ref_clk);
    bounded(200, "wake");
    chk("settle", 16'h0001, {15'h0, k >= SC});
    @(posedge ref_clk);
    irq_pin <= 1'b0;
    // Handler idles long enough for the released request to cross the synchroniser
    u_cpusbd_mem_model.mem[16'hfffc] = 8'h02;
    u_cpusbd_mem_model.mem[16'hfefc] = 8'h02;
    u_cpusbd_mem_model.mem[16'hfffd] = 8'h00;
    u_cpusbd_mem_model.mem[16'hfefd] = 8'h00;
    for (k = 0; k < 8; k++) u_cpusbd_mem_model.mem[16'h0200 + k] = k[0] ? 8'h00 : OP_ADD_SP_IMM;
    u_cpusbd_mem_model.mem[16'h0208] = OP_RET_INT;
    for (n = 0; n < 2; n++) begin
      monitor_mode <= n[0];
      break_en <= 1'b1;
      run(40'h24fe8e8e8e);
      @(posedge ref_clk);
      break_req <= 1'b1;
      for (k = 0; k < 300 && last_rd !== (n[0] ? VEC_BRK_MON : VEC_BRK); k++) @(negedge ref_clk);
      bounded(300, "vector");
      chk("vector", n[0] ? VEC_BRK_MON : VEC_BRK, last_rd);
      @(posedge ref_clk);
      break_req <= 1'b0;
      for (k = 0; k < 300 && in_break !== 1'b0; k++) @(negedge ref_clk);
      bounded(300, "break_end");
      chk("break_end", 16'h0000, {15'h0, in_break});
    end
    conclude();
  end
endmodule : test_cpusbd_core
